/* File: smr_pkg.sv */
/*
  constants for the servo monitor readback bank: variable selectors,
  word layout and reset values.
  assumes the includer runs on one clock with an active-low reset.
*/
package smr_pkg;

  localparam int SMR_SEL_W  = 5;
  localparam int SMR_WORD_W = 32;
  localparam int SMR_HALF_W = 16;
  localparam int SMR_CUR_W  = 16;
  localparam int SMR_HALL_W = 3;
  localparam int SMR_PH_W   = 3;

  // 16.16 fixed point: integer part in the high half, fraction * 65536 in the low half
  localparam int SMR_FRAC_POS = 16;
  localparam int SMR_INT_POS  = 16;

  localparam logic [SMR_SEL_W-1:0] SMR_VAR_CMD_LO   = 5'h00;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_CMD_HI   = 5'h01;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_FB_LO    = 5'h02;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_FB_HI    = 5'h03;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_PD_LO    = 5'h04;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_PD_HI    = 5'h05;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_VD_LO    = 5'h06;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_VD_HI    = 5'h07;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_FLUX_CUR = 5'h08;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_FLUX_VLT = 5'h09;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_HALL     = 5'h0a;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_PHASE    = 5'h0b;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_CUR_U    = 5'h0c;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_CUR_V    = 5'h0d;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_CUR_W    = 5'h0e;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_POS_LO   = 5'h0f;
  localparam logic [SMR_SEL_W-1:0] SMR_VAR_POS_HI   = 5'h10;

  localparam logic [SMR_WORD_W-1:0] SMR_WORD_RST  = 32'h0000_0000;
  localparam logic [SMR_CUR_W-1:0]  SMR_CUR_RST   = 16'h0000;
  localparam logic [SMR_HALL_W-1:0] SMR_HALL_RST  = 3'h0;
  localparam logic [SMR_PH_W-1:0]   SMR_PH_RST    = 3'h0;
  localparam logic [SMR_PH_W-1:0]   SMR_PH_MAX    = 3'h5;

endpackage

/* File: smr_hall_if.sv */
/*
  carrier between the readback bank and its hall decoder.
  assumes both ends sit in the same clock domain.
*/
interface smr_hall_if;
  import smr_pkg::*;

  logic [SMR_HALL_W-1:0] halls;
  logic [SMR_PH_W-1:0]   phase;
  logic                  legal;

  modport bank (output halls, input phase, input legal);
  modport dec  (input halls, output phase, output legal);
endinterface

/* File: smr_hall_decode.sv */
/*
  hall code to motor phase decoder, purely combinational.
  assumes halls are ordered {third, second, first}.
*/
module smr_hall_decode
(
  smr_hall_if.dec hif
);
  import smr_pkg::*;

  always_comb
  begin
    hif.legal = 1'b1;
    unique case (hif.halls)
      3'h1:    hif.phase = 3'h0;
      3'h3:    hif.phase = 3'h1;
      3'h2:    hif.phase = 3'h2;
      3'h6:    hif.phase = 3'h3;
      3'h4:    hif.phase = 3'h4;
      3'h5:    hif.phase = 3'h5;
      default:
      begin
        // all-low or all-high means a broken sensor; the bank keeps the last phase
        hif.phase = SMR_PH_RST;
        hif.legal = 1'b0;
      end
    endcase
  end

endmodule

/* File: smr_top.sv */
/*
  read-only monitoring bank of a servo drive: snapshots loop values on a
  control-cycle strobe and answers selector reads one cycle later.
  assumes all inputs are synchronous to mclk and stable at the sample strobe.
*/
module smr_top
#(
  parameter int WORD_W = 32,
  parameter int CUR_W  = 16
)
(
  input  wire logic                             mclk,
  input  wire logic                             nrst,
  input  wire logic                             sample,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   filtered_command,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   filtered_feedback,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   position_derivative,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   velocity_derivative,
  input  wire logic                             sine_mode,
  input  wire logic [smr_pkg::SMR_CUR_W-1:0]    flux_current_in,
  input  wire logic [smr_pkg::SMR_CUR_W-1:0]    flux_voltage_in,
  input  wire logic                             hall_input_one,
  input  wire logic                             hall_input_two,
  input  wire logic                             hall_input_three,
  input  wire logic [smr_pkg::SMR_CUR_W-1:0]    phase_u_in,
  input  wire logic [smr_pkg::SMR_CUR_W-1:0]    phase_v_in,
  input  wire logic [smr_pkg::SMR_CUR_W-1:0]    phase_w_in,
  input  wire logic                             analog_pos_fb_en,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   encoder_position,
  input  wire logic [smr_pkg::SMR_WORD_W-1:0]   analog_position,
  input  wire logic                             rd_en,
  input  wire logic [smr_pkg::SMR_SEL_W-1:0]    rd_sel,
  input  wire logic                             gather_mode,
  input  wire logic                             wr_en,
  output      logic [smr_pkg::SMR_WORD_W-1:0]   rd_data_r,
  output      logic                             rd_valid_r,
  output      logic                             rd_miss_r,
  output      logic                             wr_refused_r,
  output      logic                             hall_fault_r
);
  import smr_pkg::*;

  if (WORD_W != SMR_WORD_W || CUR_W != SMR_CUR_W)
  begin : g_chk
    $error("smr_top serves only 32-bit words and 16-bit currents");
  end

  logic                  rst_meta_r;
  logic                  rst_n_s;
  logic [WORD_W-1:0]     cmd_r;
  logic [WORD_W-1:0]     fb_r;
  logic [WORD_W-1:0]     pd_r;
  logic [WORD_W-1:0]     vd_r;
  logic [CUR_W-1:0]      flux_cur_r;
  logic [CUR_W-1:0]      flux_vlt_r;
  logic [SMR_HALL_W-1:0] hall_snapshot_r;
  logic [SMR_PH_W-1:0]   motor_phase_index_r;
  logic [CUR_W-1:0]      phase_u_current_r;
  logic [CUR_W-1:0]      phase_v_current_r;
  logic [CUR_W-1:0]      phase_w_current_r;
  logic [WORD_W-1:0]     pos_r;
  logic [WORD_W-1:0]     rd_data_nxt;
  logic                  rd_miss_nxt;

  smr_hall_if hif ();

  smr_hall_decode u_dec
  (
    .hif (hif.dec)
  );

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_r <= 1'b0;
      rst_n_s    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_s    <= rst_meta_r;
    end
  end

  // third sensor in the top bit
  assign hif.halls = {hall_input_three, hall_input_two, hall_input_one};

  // high word in both modes: integer part, sign extended
  function automatic logic [SMR_WORD_W-1:0] int_part(input logic [SMR_WORD_W-1:0] v);
    int_part = {{SMR_HALF_W{v[SMR_WORD_W-1]}}, v[SMR_WORD_W-1:SMR_INT_POS]};
  endfunction

  // low word: the whole value outside gathering, only the low half when gathered
  function automatic logic [SMR_WORD_W-1:0] low_word(input logic [SMR_WORD_W-1:0] v, input logic g);
    low_word = g ? {{SMR_HALF_W{1'b0}}, v[SMR_FRAC_POS-1:0]} : v;
  endfunction

  function automatic logic [SMR_WORD_W-1:0] sext16(input logic [SMR_CUR_W-1:0] v);
    sext16 = {{(SMR_WORD_W-SMR_CUR_W){v[SMR_CUR_W-1]}}, v};
  endfunction

  // one strobe latches every word, so word pairs never tear across cycles
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      cmd_r <= SMR_WORD_RST;
      fb_r  <= SMR_WORD_RST;
      pd_r  <= SMR_WORD_RST;
      vd_r  <= SMR_WORD_RST;
    end
    else if (sample)
    begin
      cmd_r <= filtered_command;
      fb_r  <= filtered_feedback;
      pd_r  <= position_derivative;
      vd_r  <= velocity_derivative;
    end
  end

  // position source follows analog feedback enable
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      pos_r <= SMR_WORD_RST;
    else if (sample)
      pos_r <= analog_pos_fb_en ? analog_position : encoder_position;
  end

  // flux current only meaningful in sine mode; trapezoidal reads zero
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      flux_cur_r <= SMR_CUR_RST;
      flux_vlt_r <= SMR_CUR_RST;
    end
    else if (sample)
    begin
      flux_cur_r <= sine_mode ? flux_current_in : SMR_CUR_RST;
      flux_vlt_r <= sine_mode ? flux_voltage_in : SMR_CUR_RST;
    end
  end

  // raw hall bits; phase held over an illegal code
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      hall_snapshot_r     <= SMR_HALL_RST;
      motor_phase_index_r <= SMR_PH_RST;
      hall_fault_r        <= 1'b0;
    end
    else if (sample)
    begin
      hall_snapshot_r <= hif.halls;
      hall_fault_r    <= !hif.legal;
      if (hif.legal)
        motor_phase_index_r <= hif.phase;
    end
  end

  // phase currents stored as signed 16-bit
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      phase_u_current_r <= SMR_CUR_RST;
      phase_v_current_r <= SMR_CUR_RST;
      phase_w_current_r <= SMR_CUR_RST;
    end
    else if (sample)
    begin
      phase_u_current_r <= phase_u_in;
      phase_v_current_r <= phase_v_in;
      phase_w_current_r <= phase_w_in;
    end
  end

  always_comb
  begin
    rd_miss_nxt = 1'b0;
    rd_data_nxt = SMR_WORD_RST;
    unique case (rd_sel)
      SMR_VAR_CMD_LO:   rd_data_nxt = low_word(cmd_r, gather_mode);
      SMR_VAR_CMD_HI:   rd_data_nxt = int_part(cmd_r);
      SMR_VAR_FB_LO:    rd_data_nxt = low_word(fb_r, gather_mode);
      SMR_VAR_FB_HI:    rd_data_nxt = int_part(fb_r);
      SMR_VAR_PD_LO:    rd_data_nxt = low_word(pd_r, gather_mode);
      SMR_VAR_PD_HI:    rd_data_nxt = int_part(pd_r);
      SMR_VAR_VD_LO:    rd_data_nxt = low_word(vd_r, gather_mode);
      SMR_VAR_VD_HI:    rd_data_nxt = int_part(vd_r);
      SMR_VAR_FLUX_CUR: rd_data_nxt = sext16(flux_cur_r);
      SMR_VAR_FLUX_VLT: rd_data_nxt = sext16(flux_vlt_r);
      SMR_VAR_HALL:     rd_data_nxt = {{(SMR_WORD_W-SMR_HALL_W){1'b0}}, hall_snapshot_r};
      SMR_VAR_PHASE:    rd_data_nxt = {{(SMR_WORD_W-SMR_PH_W){1'b0}}, motor_phase_index_r};
      SMR_VAR_CUR_U:    rd_data_nxt = sext16(phase_u_current_r);
      SMR_VAR_CUR_V:    rd_data_nxt = sext16(phase_v_current_r);
      SMR_VAR_CUR_W:    rd_data_nxt = sext16(phase_w_current_r);
      // low word combined outside gathering; gatherers take both
      SMR_VAR_POS_LO:   rd_data_nxt = low_word(pos_r, gather_mode);
      SMR_VAR_POS_HI:   rd_data_nxt = int_part(pos_r);
      default:          rd_miss_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      rd_data_r  <= SMR_WORD_RST;
      rd_valid_r <= 1'b0;
      rd_miss_r  <= 1'b0;
    end
    else
    begin
      rd_valid_r <= rd_en;
      rd_miss_r  <= rd_en && rd_miss_nxt;
      if (rd_en)
        rd_data_r <= rd_data_nxt;
    end
  end

  // nothing in the bank is writable; a write only raises a one-cycle refusal
  always_ff @(posedge mclk or negedge rst_n_s)
  begin
    if (!rst_n_s)
      wr_refused_r <= 1'b0;
    else
      wr_refused_r <= wr_en;
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n_s);

  chk_cmd_high: assert property (rd_en && rd_sel == SMR_VAR_CMD_HI && !sample |=>
    rd_data_r == {{16{cmd_r[31]}}, cmd_r[31:16]}) else $error("command high word wrong");
  chk_feedback_low: assert property (rd_en && rd_sel == SMR_VAR_FB_LO && !gather_mode |=>
    rd_data_r == $past(fb_r)) else $error("feedback low word not whole value");
  chk_pderiv_gather: assert property (rd_en && rd_sel == SMR_VAR_PD_LO && gather_mode |=>
    rd_data_r == {16'h0000, $past(pd_r[15:0])}) else $error("gathered position derivative low wrong");
  chk_vderiv_high: assert property (rd_en && rd_sel == SMR_VAR_VD_HI |=>
    rd_data_r[15:0] == $past(vd_r[31:16])) else $error("velocity derivative high word wrong");
  chk_write_refused: assert property (wr_en && !sample |=> wr_refused_r && $stable(cmd_r) && $stable(pos_r))
    else $error("write not refused or altered bank");
  chk_flux_trap: assert property (sample && !sine_mode |=> flux_cur_r == 16'h0000)
    else $error("flux current outside sine mode");
  chk_flux_volt: assert property (sample && sine_mode |=> flux_vlt_r == $past(flux_voltage_in))
    else $error("flux voltage not captured");
  chk_hall_order: assert property (sample |=>
    hall_snapshot_r == $past({hall_input_three, hall_input_two, hall_input_one})) else $error("hall order wrong");
  chk_phase_range: assert property (motor_phase_index_r <= SMR_PH_MAX)
    else $error("motor phase out of range");
  chk_cur_sign: assert property (rd_en && rd_sel == SMR_VAR_CUR_U && !sample |=>
    rd_data_r == {{16{phase_u_current_r[15]}}, phase_u_current_r}) else $error("phase current sign wrong");
  chk_pos_combined: assert property (rd_en && rd_sel == SMR_VAR_POS_LO && !gather_mode |=>
    rd_data_r == $past(pos_r)) else $error("position low not combined");
  chk_pos_source: assert property (sample && !analog_pos_fb_en |=> pos_r == $past(encoder_position))
    else $error("position not from encoder");
  chk_snap_atomic: assert property (!sample |=> $stable(cmd_r) && $stable(pos_r) && $stable(pd_r))
    else $error("snapshot moved without strobe");
  chk_read_valid: assert property (rd_en |=> rd_valid_r ##1 !rd_valid_r || $past(rd_en))
    else $error("read answer timing wrong");
  // the range check above cannot fail on its own, so the decode and hold paths are checked directly
  chk_phase_hold: assert property (sample && !hif.legal |=> hall_fault_r && $stable(motor_phase_index_r))
    else $error("phase not held over illegal hall code");
  chk_phase_code: assert property (sample && hif.halls == 3'h6 |=> motor_phase_index_r == 3'h3)
    else $error("hall code 110 not decoded to phase 3");
  chk_fault_clear: assert property (sample && hif.legal |=> !hall_fault_r)
    else $error("hall fault raised on a legal code");
  chk_flux_vtrap: assert property (sample && !sine_mode |=> flux_vlt_r == 16'h0000)
    else $error("flux voltage outside sine mode");
  chk_cmd_gather: assert property (rd_en && rd_sel == SMR_VAR_CMD_LO && gather_mode |=>
    rd_data_r == {16'h0000, $past(cmd_r[15:0])}) else $error("gathered command low word wrong");
  chk_pos_high: assert property (rd_en && rd_sel == SMR_VAR_POS_HI && !sample |=>
    rd_data_r == {{16{pos_r[31]}}, pos_r[31:16]}) else $error("position high word wrong");
  chk_read_miss: assert property (rd_en && rd_sel > SMR_VAR_POS_HI |=> rd_miss_r && rd_data_r == 32'h0000_0000)
    else $error("unmapped read not refused");

  cov_gather_read: cover property (rd_en && gather_mode && rd_sel == SMR_VAR_POS_LO ##1 rd_valid_r);
  cov_sine_sample: cover property (sample && sine_mode ##1 sample && !sine_mode);
  cov_hall_fault:  cover property (sample && !hif.legal ##1 hall_fault_r);
  cov_read_miss:   cover property (rd_en && rd_sel == 5'h1f ##1 rd_miss_r);
  cov_analog_pos:  cover property (sample && analog_pos_fb_en ##2 rd_en && rd_sel == SMR_VAR_POS_LO);

endmodule

/* File: tb_servo_monitor_readback.sv */
/*
  self-checking bench for the servo monitor readback bank (smr_top).
  assumes smr_pkg is compiled first and the bank answers reads one cycle after rd_en.
*/
module tb_servo_monitor_readback
  import smr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                  mclk, nrst, sample, sine_mode, analog_pos_fb_en;
  logic                  hall_input_one, hall_input_two, hall_input_three;
  logic                  rd_en, gather_mode, wr_en;
  logic [SMR_SEL_W-1:0]  rd_sel;
  logic [SMR_WORD_W-1:0] filtered_command, filtered_feedback, position_derivative, velocity_derivative;
  logic [SMR_WORD_W-1:0] encoder_position, analog_position, rd_data_r;
  logic [SMR_CUR_W-1:0]  flux_current_in, flux_voltage_in, phase_u_in, phase_v_in, phase_w_in;
  logic                  rd_valid_r, rd_miss_r, wr_refused_r, hall_fault_r;
  int                    num_errors;
  int                    compares;

  smr_top dut_u
  (
    .mclk, .nrst, .sample, .filtered_command, .filtered_feedback, .position_derivative,
    .velocity_derivative, .sine_mode, .flux_current_in, .flux_voltage_in, .hall_input_one,
    .hall_input_two, .hall_input_three, .phase_u_in, .phase_v_in, .phase_w_in, .analog_pos_fb_en,
    .encoder_position, .analog_position, .rd_en, .rd_sel, .gather_mode, .wr_en, .rd_data_r,
    .rd_valid_r, .rd_miss_r, .wr_refused_r, .hall_fault_r
  );

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [SMR_WORD_W-1:0] hi(input logic [SMR_WORD_W-1:0] v);
    return {{16{v[31]}}, v[31:16]};
  endfunction

  function automatic logic [SMR_WORD_W-1:0] sx(input logic [SMR_CUR_W-1:0] c);
    return {{16{c[15]}}, c};
  endfunction

  task automatic chk(input logic [SMR_WORD_W-1:0] got, input logic [SMR_WORD_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one sample strobe; caller has set the inputs at this same edge
  task automatic pulse;
    sample <= 1'b1;
    @(posedge mclk);
    sample <= 1'b0;
  endtask

  task automatic rd(input logic [SMR_SEL_W-1:0] s, input logic g, input logic [SMR_WORD_W-1:0] exp,
                    input logic miss);
    @(posedge mclk);
    rd_en       <= 1'b1;
    rd_sel      <= s;
    gather_mode <= g;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk({30'h0, rd_valid_r, rd_miss_r}, {30'h0, 1'b1, miss});
    chk(rd_data_r, exp);
  endtask

  task automatic t_fixed;
    logic [SMR_WORD_W-1:0] v [4];
    v = '{32'hfffe_8000, 32'h0003_4000, 32'h8000_0001, 32'h7fff_ffff};
    @(posedge mclk);
    filtered_command    <= v[0];
    filtered_feedback   <= v[1];
    position_derivative <= v[2];
    velocity_derivative <= v[3];
    pulse();
    for (int i = 0; i < 4; i++)
    begin
      rd(5'(2 * i), 1'b0, v[i], 1'b0);
      rd(5'(2 * i + 1), 1'b0, hi(v[i]), 1'b0);
      rd(5'(2 * i), 1'b1, {16'h0000, v[i][15:0]}, 1'b0);
      rd(5'(2 * i + 1), 1'b1, hi(v[i]), 1'b0);
    end
  endtask

  task automatic t_flux;
    @(posedge mclk);
    sine_mode       <= 1'b1;
    flux_current_in <= 16'h8000;
    flux_voltage_in <= 16'h7fff;
    pulse();
    rd(SMR_VAR_FLUX_CUR, 1'b0, sx(16'h8000), 1'b0);
    rd(SMR_VAR_FLUX_VLT, 1'b0, sx(16'h7fff), 1'b0);
    @(posedge mclk);
    sine_mode <= 1'b0;
    pulse();
    rd(SMR_VAR_FLUX_CUR, 1'b0, 32'h0000_0000, 1'b0);
    rd(SMR_VAR_FLUX_VLT, 1'b0, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_hall;
    logic [2:0] ptab [8];
    logic [2:0] code;
    logic [2:0] ph;
    ptab = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h4, 3'h5, 3'h3, 3'h0};
    ph   = 3'h0;
    // codes 1..7 then 0, so both illegal codes follow a legal phase
    for (int c = 1; c <= 8; c++)
    begin
      code = 3'(c);
      @(posedge mclk);
      {hall_input_three, hall_input_two, hall_input_one} <= code;
      pulse();
      if (code != 3'h0 && code != 3'h7)
        ph = ptab[code];
      rd(SMR_VAR_HALL, 1'b0, {29'h0, code}, 1'b0);
      rd(SMR_VAR_PHASE, 1'b0, {29'h0, ph}, 1'b0);
      chk({31'h0, hall_fault_r}, {31'h0, code == 3'h0 || code == 3'h7});
    end
  endtask

  task automatic t_cur;
    @(posedge mclk);
    phase_u_in <= 16'h8000;
    phase_v_in <= 16'h7fff;
    phase_w_in <= 16'hffff;
    pulse();
    rd(SMR_VAR_CUR_U, 1'b0, sx(16'h8000), 1'b0);
    rd(SMR_VAR_CUR_V, 1'b0, sx(16'h7fff), 1'b0);
    rd(SMR_VAR_CUR_W, 1'b0, sx(16'hffff), 1'b0);
  endtask

  task automatic t_pos;
    @(posedge mclk);
    encoder_position <= 32'h8000_0000;
    analog_position  <= 32'h1234_5678;
    analog_pos_fb_en <= 1'b0;
    pulse();
    rd(SMR_VAR_POS_LO, 1'b0, 32'h8000_0000, 1'b0);
    rd(SMR_VAR_POS_LO, 1'b1, 32'h0000_0000, 1'b0);
    rd(SMR_VAR_POS_HI, 1'b1, 32'hffff_8000, 1'b0);
    @(posedge mclk);
    analog_pos_fb_en <= 1'b1;
    pulse();
    rd(SMR_VAR_POS_LO, 1'b0, 32'h1234_5678, 1'b0);
    rd(SMR_VAR_POS_HI, 1'b0, 32'h0000_1234, 1'b0);
  endtask

  task automatic t_write;
    @(posedge mclk);
    wr_en  <= 1'b1;
    rd_sel <= SMR_VAR_CMD_LO;
    @(posedge mclk);
    wr_en <= 1'b0;
    #1;
    chk({31'h0, wr_refused_r}, 32'h0000_0001);
    rd(SMR_VAR_CMD_LO, 1'b0, 32'hfffe_8000, 1'b0);
    rd(5'h11, 1'b0, 32'h0000_0000, 1'b1);
    rd(5'h1f, 1'b0, 32'h0000_0000, 1'b1);
  endtask

  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  initial
  begin
    num_errors = 0;
    compares   = 0;
    nrst = 1'b0;
    {sample, sine_mode, analog_pos_fb_en, rd_en, gather_mode, wr_en} = '0;
    {hall_input_one, hall_input_two, hall_input_three} = 3'h1;
    rd_sel = '0;
    {filtered_command, filtered_feedback, position_derivative, velocity_derivative} = '0;
    {encoder_position, analog_position} = '0;
    {flux_current_in, flux_voltage_in, phase_u_in, phase_v_in, phase_w_in} = '0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    // release passes two flops inside; give it room before the first request
    repeat (3) @(posedge mclk);
    t_fixed();
    t_flux();
    t_hall();
    t_cur();
    t_pos();
    t_write();
    conclude();
  end
endmodule
